// [common/redriver_cfg_pkg.sv]
// constants and types shared by the lane configuration register bank
// Contract
// - general bit 5 set swaps the hot-plug input from its default pin to the alternate pin.
// - general bit 4 picks strap-sampled equalizer settings when 0 and register values when 1.
// - general bit 3 set forces the internal hot-plug input high, else it follows the pin.
// - lane_config_select 00 disables all, 01 usb only, 10 four display lanes, 11 two plus usb.
// - each display lane has a four-bit equalizer field, lanes 1/0 at 0x10 and 3/2 at 0x11.
// - with software control off, hardware keeps every lane equalizer field at the strap value.
// - with software control on, each lane equalizer keeps its register value, the last strap value until software writes it.
// - bits 6:5 of the snoop status capture sideband writes to sink address 0x00600, read-only.
// - bits 4:0 of the snoop status capture sideband writes to sink address 0x00101, read-only.
// - with snooping enabled, display lanes follow the captured sink power state.
// - with snooping enabled, only lanes named by the captured lane count are powered.
// - with snooping disabled, lane enables come from the lane configuration masked by the per_lane_off bits.
// - the captured sink power clears when lane_config_select bit 1 falls from 1 to 0.
// - the captured lane count clears when lane_config_select bit 1 falls from 1 to 0.
// - the snoop control bit enables snooping at 0, the reset value, and disables it at 1.
// - per_lane_off 1 turns its lane off, 0 on, and only matters while snooping is disabled.
package redriver_cfg_pkg;

  // register offsets
  localparam logic [7:0] GENERAL_CONTROL_ADDR = 8'h0a;
  localparam logic [7:0] DP_EQ_LANES_0_1_ADDR = 8'h10;
  localparam logic [7:0] DP_EQ_LANES_2_3_ADDR = 8'h11;
  localparam logic [7:0] SIDEBAND_SNOOP_STATUS_ADDR = 8'h12;
  localparam logic [7:0] SNOOP_LANE_CONTROL_ADDR = 8'h13;

  // reset values
  localparam logic [7:0] GENERAL_CONTROL_RST = 8'h01;
  localparam logic [7:0] DP_EQ_RST = 8'h00;
  localparam logic [6:0] SNOOP_STATUS_RST = 7'h00;
  localparam logic [7:0] SNOOP_LANE_CONTROL_RST = 8'h00;

  // general_control fields
  localparam int LANE_CONFIG_LSB = 0;
  localparam int ORIENTATION_BIT = 2;
  localparam int HOTPLUG_FORCE_BIT = 3;
  localparam int EQ_SW_CONTROL_BIT = 4;
  localparam int HPD_SWAP_BIT = 5;
  localparam logic [7:0] GENERAL_WRITE_MASK = 8'h3f;

  // snoop control register fields
  localparam int SNOOP_DISABLE_BIT = 7;
  localparam logic [7:0] SNOOP_LANE_WRITE_MASK = 8'hbf;

  // snoop status fields
  localparam int SINK_POWER_LSB = 5;
  localparam int LANE_TOTAL_LSB = 0;

  // lane configurations
  localparam logic [1:0] LANE_CFG_OFF = 2'b00;
  localparam logic [1:0] LANE_CFG_USB = 2'b01;
  localparam logic [1:0] LANE_CFG_DP4 = 2'b10;
  localparam logic [1:0] LANE_CFG_DP2_USB = 2'b11;

  // sideband sink addresses watched by the snooper
  localparam logic [19:0] SINK_POWER_ADDR = 20'h00600;
  localparam logic [19:0] SINK_LANE_COUNT_ADDR = 20'h00101;
  localparam logic [1:0] SINK_POWER_ON = 2'b01;

  // strap code to equalizer level
  localparam logic [3:0] EQ_STRAP_LEVEL_0 = 4'h0;
  localparam logic [3:0] EQ_STRAP_LEVEL_1 = 4'h5;
  localparam logic [3:0] EQ_STRAP_LEVEL_2 = 4'ha;
  localparam logic [3:0] EQ_STRAP_LEVEL_3 = 4'he;

  // serial target address, arbitrary value
  localparam logic [6:0] TARGET_ADDR_DEFAULT = 7'h2a;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_SUB,
    ST_WDATA,
    ST_ACK,
    ST_RDATA,
    ST_RACK
  } serial_state_type;

endpackage : redriver_cfg_pkg

// [design/redriver_lane_config_regs.sv]
// serial-programmed lane configuration and sideband snoop register bank
`timescale 1ns/1ns
module redriver_lane_config_regs #(
  parameter logic [6:0] TARGET_ADDR = redriver_cfg_pkg::TARGET_ADDR_DEFAULT
) (
  input wire logic clk_i,                 // register logic clock
  input wire logic rst_n_i,               // async reset, active low
  input wire logic scl_i,                 // serial clock pin
  input wire logic sda_i,                 // serial data pin level
  output logic sda_o,                     // serial data drive value
  output logic sda_oe_o,                  // serial data pulled low when high
  input wire logic hotplug_pin_a_i,       // hot-plug default pin
  input wire logic hotplug_pin_b_i,       // hot-plug alternate pin
  input wire logic [1:0] display_eq_pins_i, // display equalizer straps
  input wire logic snoop_wr_i,            // sideband write seen, one cycle
  input wire logic [19:0] snoop_addr_i,   // sideband write sink address
  input wire logic [7:0] snoop_data_i,    // sideband write value
  output logic hotplug_o,                 // internal hot-plug level
  output logic [1:0] lane_config_select_o, // lane configuration
  output logic orientation_select_o,      // to crosspoint mux
  output logic usb_en_o,                  // usb link enabled
  output logic [3:0] dp_lane_en_o,        // display lane enables
  output logic [15:0] dp_eq_level_o       // lane 3..0 equalizer levels
);
  import redriver_cfg_pkg::*;

  typedef struct packed {
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic [2:0] hpa_s;
    logic [2:0] hpb_s;
    logic [2:0] eq0_s;
    logic [2:0] eq1_s;
    logic scl_f;
    logic sda_f;
    logic hpa_f;
    logic hpb_f;
    logic [1:0] eq_f;
    serial_state_type st;
    serial_state_type after;
    logic [3:0] cnt;
    logic [7:0] sr;
    logic nack;
    logic [7:0] ptr;
    logic [7:0] general;
    logic [7:0] eq01;
    logic [7:0] eq23;
    logic [6:0] snoop;
    logic [7:0] lanectl;
    logic hotplug;
    logic [3:0] lane_en;
  } state_type;

  state_type cur;
  state_type next_cur;

  // a change counts once the second and third stages agree
  function automatic logic filt(input logic old, input logic [2:0] s);
    filt = (s[1] == s[2]) ? s[2] : old;
  endfunction : filt

  function automatic logic [3:0] strap_level(input logic [1:0] code);
    unique case (code)
      2'b00: strap_level = EQ_STRAP_LEVEL_0;
      2'b01: strap_level = EQ_STRAP_LEVEL_1;
      2'b10: strap_level = EQ_STRAP_LEVEL_2;
      2'b11: strap_level = EQ_STRAP_LEVEL_3;
    endcase
  endfunction : strap_level

  function automatic logic [3:0] count_mask(input logic [4:0] total);
    case (total)
      5'h01: count_mask = 4'h1;
      5'h02: count_mask = 4'h3;
      5'h04: count_mask = 4'hf;
      default: count_mask = 4'h0;
    endcase
  endfunction : count_mask

  function automatic logic [7:0] read_reg(input state_type s, input logic [7:0] a);
    case (a)
      GENERAL_CONTROL_ADDR: read_reg = s.general;
      DP_EQ_LANES_0_1_ADDR: read_reg = s.eq01;
      DP_EQ_LANES_2_3_ADDR: read_reg = s.eq23;
      SIDEBAND_SNOOP_STATUS_ADDR: read_reg = {1'b0, s.snoop};
      SNOOP_LANE_CONTROL_ADDR: read_reg = s.lanectl;
      default: read_reg = 8'h00;
    endcase
  endfunction : read_reg

  ////////////////////////////////////////////////////////////////////////////
  logic scl_new;
  logic sda_new;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic [3:0] base_en;
  logic [3:0] snoop_en;
  logic hp_sel;

  always_comb begin
    next_cur = cur;
    next_cur.scl_s = {cur.scl_s[1:0], scl_i};
    next_cur.sda_s = {cur.sda_s[1:0], sda_i};
    next_cur.hpa_s = {cur.hpa_s[1:0], hotplug_pin_a_i};
    next_cur.hpb_s = {cur.hpb_s[1:0], hotplug_pin_b_i};
    next_cur.eq0_s = {cur.eq0_s[1:0], display_eq_pins_i[0]};
    next_cur.eq1_s = {cur.eq1_s[1:0], display_eq_pins_i[1]};
    scl_new = filt(cur.scl_f, cur.scl_s);
    sda_new = filt(cur.sda_f, cur.sda_s);
    next_cur.scl_f = scl_new;
    next_cur.sda_f = sda_new;
    next_cur.hpa_f = filt(cur.hpa_f, cur.hpa_s);
    next_cur.hpb_f = filt(cur.hpb_f, cur.hpb_s);
    next_cur.eq_f = {filt(cur.eq_f[1], cur.eq1_s), filt(cur.eq_f[0], cur.eq0_s)};
    scl_rise = scl_new & ~cur.scl_f;
    scl_fall = ~scl_new & cur.scl_f;
    start_seen = cur.scl_f & scl_new & cur.sda_f & ~sda_new;
    stop_seen = cur.scl_f & scl_new & ~cur.sda_f & sda_new;

    // serial target
    if (start_seen) begin
      next_cur.st = ST_ADDR;
      next_cur.cnt = 4'h0;
    end else if (stop_seen) begin
      next_cur.st = ST_IDLE;
      next_cur.cnt = 4'h0;
    end else if (scl_rise) begin
      unique case (cur.st)
        ST_ADDR, ST_SUB, ST_WDATA: begin
          next_cur.sr = {cur.sr[6:0], sda_new};
          next_cur.cnt = cur.cnt + 4'h1;
        end
        ST_RDATA: next_cur.cnt = cur.cnt + 4'h1;
        ST_RACK: next_cur.nack = sda_new;
        ST_IDLE, ST_ACK: ;
      endcase
    end else if (scl_fall) begin
      unique case (cur.st)
        ST_ADDR: if (cur.cnt == BITS_PER_BYTE) begin
          if (cur.sr[7:1] == TARGET_ADDR) begin
            next_cur.st = ST_ACK;
            next_cur.after = cur.sr[0] ? ST_RDATA : ST_SUB;
          end else begin
            next_cur.st = ST_IDLE;
          end
        end
        ST_SUB: if (cur.cnt == BITS_PER_BYTE) begin
          next_cur.ptr = cur.sr;
          next_cur.st = ST_ACK;
          next_cur.after = ST_WDATA;
        end
        ST_WDATA: if (cur.cnt == BITS_PER_BYTE) begin
          case (cur.ptr)
            GENERAL_CONTROL_ADDR: next_cur.general = cur.sr & GENERAL_WRITE_MASK;
            DP_EQ_LANES_0_1_ADDR: next_cur.eq01 = cur.sr;
            DP_EQ_LANES_2_3_ADDR: next_cur.eq23 = cur.sr;
            SNOOP_LANE_CONTROL_ADDR: next_cur.lanectl = cur.sr & SNOOP_LANE_WRITE_MASK;
            default: ;
          endcase
          next_cur.ptr = cur.ptr + 8'h01;
          next_cur.st = ST_ACK;
          next_cur.after = ST_WDATA;
        end
        ST_ACK: begin
          next_cur.st = cur.after;
          next_cur.cnt = 4'h0;
          if (cur.after == ST_RDATA) begin
            next_cur.sr = read_reg(cur, cur.ptr);
            next_cur.ptr = cur.ptr + 8'h01;
          end
        end
        ST_RDATA: begin
          if (cur.cnt == BITS_PER_BYTE) begin
            next_cur.st = ST_RACK;
          end else begin
            next_cur.sr = {cur.sr[6:0], 1'b0};
          end
        end
        ST_RACK: begin
          if (cur.nack) begin
            next_cur.st = ST_IDLE;
          end else begin
            next_cur.st = ST_RDATA;
            next_cur.cnt = 4'h0;
            next_cur.sr = read_reg(cur, cur.ptr);
            next_cur.ptr = cur.ptr + 8'h01;
          end
        end
        ST_IDLE: ;
      endcase
    end

    // strap sampling overwrites writes while software control is off
    if (!cur.general[EQ_SW_CONTROL_BIT]) begin
      next_cur.eq01 = {2{strap_level(cur.eq_f)}};
      next_cur.eq23 = {2{strap_level(cur.eq_f)}};
    end

    // sideband capture, ignored while snooping is disabled
    if (snoop_wr_i && !cur.lanectl[SNOOP_DISABLE_BIT]) begin
      if (snoop_addr_i == SINK_POWER_ADDR) begin
        next_cur.snoop[SINK_POWER_LSB +: 2] = snoop_data_i[1:0];
      end
      if (snoop_addr_i == SINK_LANE_COUNT_ADDR) begin
        next_cur.snoop[LANE_TOTAL_LSB +: 5] = snoop_data_i[4:0];
      end
    end
    // leaving a display configuration drops stale link state
    if (cur.general[LANE_CONFIG_LSB + 1] && !next_cur.general[LANE_CONFIG_LSB + 1]) begin
      next_cur.snoop[SINK_POWER_LSB +: 2] = 2'b00;
      next_cur.snoop[LANE_TOTAL_LSB +: 5] = 5'h00;
    end

    // hot-plug source
    hp_sel = cur.general[HPD_SWAP_BIT] ? cur.hpb_f : cur.hpa_f;
    next_cur.hotplug = cur.general[HOTPLUG_FORCE_BIT] | hp_sel;

    // lane enables
    unique case (cur.general[LANE_CONFIG_LSB +: 2])
      LANE_CFG_OFF: base_en = 4'h0;
      LANE_CFG_USB: base_en = 4'h0;
      LANE_CFG_DP4: base_en = 4'hf;
      LANE_CFG_DP2_USB: base_en = 4'h3;
    endcase
    snoop_en = (cur.snoop[SINK_POWER_LSB +: 2] == SINK_POWER_ON) ?
      count_mask(cur.snoop[LANE_TOTAL_LSB +: 5]) : 4'h0;
    if (cur.lanectl[SNOOP_DISABLE_BIT]) begin
      next_cur.lane_en = base_en & ~cur.lanectl[3:0];
    end else begin
      next_cur.lane_en = base_en & snoop_en;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cur <= '0;
      cur.scl_s <= 3'h7;
      cur.sda_s <= 3'h7;
      cur.scl_f <= 1'b1;
      cur.sda_f <= 1'b1;
      cur.st <= ST_IDLE;
      cur.after <= ST_IDLE;
      cur.general <= GENERAL_CONTROL_RST;
      cur.eq01 <= DP_EQ_RST;
      cur.eq23 <= DP_EQ_RST;
      cur.snoop <= SNOOP_STATUS_RST;
      cur.lanectl <= SNOOP_LANE_CONTROL_RST;
    end else begin
      cur <= next_cur;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // open drain: only ever pulls low
  assign sda_o = 1'b0;
  assign sda_oe_o = (cur.st == ST_ACK) | ((cur.st == ST_RDATA) & ~cur.sr[7]);
  assign hotplug_o = cur.hotplug;
  assign lane_config_select_o = cur.general[LANE_CONFIG_LSB +: 2];
  assign orientation_select_o = cur.general[ORIENTATION_BIT];
  assign usb_en_o = cur.general[LANE_CONFIG_LSB];
  assign dp_lane_en_o = cur.lane_en;
  assign dp_eq_level_o = {cur.eq23, cur.eq01};

endmodule : redriver_lane_config_regs

// [test/redriver_cfg_properties.sv]
// port-level checker for the lane configuration register bank
`timescale 1ns/1ns
module redriver_cfg_checker
  import redriver_cfg_pkg::*;
(
  input wire logic clk_i,                  // register clock
  input wire logic rst_n_i,                // async reset, active low
  input wire logic scl_i,                  // serial clock pin
  input wire logic sda_i,                  // serial data wire
  input wire logic sda_o,                  // data drive value
  input wire logic sda_oe_o,               // data pull enable
  input wire logic hotplug_pin_a_i,        // default hot-plug pin
  input wire logic hotplug_pin_b_i,        // alternate hot-plug pin
  input wire logic [1:0] display_eq_pins_i, // equalizer straps
  input wire logic snoop_wr_i,             // sideband write seen
  input wire logic [19:0] snoop_addr_i,    // sideband address
  input wire logic [7:0] snoop_data_i,     // sideband value
  input wire logic hotplug_o,              // internal hot-plug
  input wire logic [1:0] lane_config_select_o, // lane configuration
  input wire logic orientation_select_o,   // to crosspoint mux
  input wire logic usb_en_o,               // usb link enable
  input wire logic [3:0] dp_lane_en_o,     // display lane enables
  input wire logic [15:0] dp_eq_level_o    // equalizer levels
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // scl high long enough that no byte can have been acted on
  sequence scl_held;
    scl_i [*8];
  endsequence
  sequence eq_calm;
    (scl_i && $stable(display_eq_pins_i)) [*8];
  endsequence
  sequence both_pins_high;
    (hotplug_pin_a_i && hotplug_pin_b_i) [*8];
  endsequence
  chk_reset_defaults: assert property ($rose(rst_n_i) |-> lane_config_select_o == LANE_CFG_USB
    && usb_en_o && !orientation_select_o && dp_lane_en_o == 4'h0) else $error("bad defaults");
  chk_usb_tracks_cfg: assert property (usb_en_o == lane_config_select_o[0])
    else $error("usb enable off config");
  chk_off_no_lanes: assert property (!lane_config_select_o[1] &&
    !$past(lane_config_select_o[1]) |-> dp_lane_en_o == 4'h0) else $error("lanes on in usb config");
  chk_dp2_upper_off: assert property (lane_config_select_o == LANE_CFG_DP2_USB &&
    $past(lane_config_select_o) == LANE_CFG_DP2_USB |-> dp_lane_en_o[3:2] == 2'b00)
    else $error("upper lanes on in two-lane config");
  chk_cfg_quiet: assert property (scl_held |-> $stable(lane_config_select_o) &&
    $stable(orientation_select_o)) else $error("config moved without a write");
  chk_lanes_quiet: assert property (scl_held ##0 (!$past(snoop_wr_i) &&
    !$past(snoop_wr_i, 2) && !$past(snoop_wr_i, 3)) |-> $stable(dp_lane_en_o))
    else $error("lane enables moved without cause");
  chk_eq_quiet: assert property (eq_calm |-> $stable(dp_eq_level_o))
    else $error("equalizer moved without cause");
  chk_hotplug_high: assert property (both_pins_high |-> hotplug_o)
    else $error("hot-plug low with both pins high");
endmodule : redriver_cfg_checker

// [test/i2c_host_model.sv]
// serial bus host that programs the register bank
`timescale 1ns/1ns
module i2c_host_model (
  input wire logic clk_i,   // bench clock, paces the bus
  input wire logic sda_i,   // resolved data wire
  output logic scl_o,       // serial clock
  output logic sda_low_o    // high pulls data low
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // quarter bit; data moves mid-low so the target's late pin view never sees a false start
  task automatic hp();
    repeat (6) @(negedge clk_i);
  endtask : hp
  task automatic start();
    sda_low_o = 1'b0;
    hp();
    scl_o = 1'b1;
    hp();
    sda_low_o = 1'b1;
    hp();
    scl_o = 1'b0;
  endtask : start
  task automatic stop();
    hp();
    sda_low_o = 1'b1;
    hp();
    scl_o = 1'b1;
    hp();
    sda_low_o = 1'b0;
    hp();
  endtask : stop
  task automatic bit_x(input logic b, output logic r);
    hp();
    sda_low_o = ~b;
    hp();
    scl_o = 1'b1;
    hp();
    r = sda_i;
    hp();
    scl_o = 1'b0;
  endtask : bit_x
  task automatic byte_x(input logic [7:0] d, input logic ack_bit, output logic [7:0] q,
                        output logic a);
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], q[i]);
    end
    bit_x(ack_bit, a);
  endtask : byte_x
endmodule : i2c_host_model

// [test/redriver_lane_config_regs_tb.sv]
// self-checking bench for the lane configuration register bank
`timescale 1ns/1ns
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module redriver_lane_config_regs_tb;
  import redriver_cfg_pkg::*;
  logic clk_i, rst_n_i, pin_a, pin_b, snoop_wr;
  logic [1:0] straps;
  logic [19:0] snoop_addr;
  logic [7:0] snoop_data;
  logic [3:0] base [4] = '{4'h0, 4'h0, 4'hf, 4'h3};
  wire scl, host_low, sda_oe, sda_out, sda_w, hotplug, orient, usb_en;
  wire [1:0] cfg;
  wire [3:0] lane_en;
  wire [15:0] eq;
  int err_count = 0;
  int samples_checked = 0;
  assign sda_w = ~(sda_oe | host_low); // pull-up on the wire
  redriver_lane_config_regs dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_out), .sda_oe_o(sda_oe), .hotplug_pin_a_i(pin_a), .hotplug_pin_b_i(pin_b),
    .display_eq_pins_i(straps), .snoop_wr_i(snoop_wr), .snoop_addr_i(snoop_addr),
    .snoop_data_i(snoop_data), .hotplug_o(hotplug), .lane_config_select_o(cfg),
    .orientation_select_o(orient), .usb_en_o(usb_en), .dp_lane_en_o(lane_en), .dp_eq_level_o(eq));
  i2c_host_model host_u (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl), .sda_low_o(host_low));
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  task automatic wb(input logic [7:0] d);
    logic [7:0] q;
    logic a;
    host_u.byte_x(d, 1'b1, q, a);
    `CHK(a, 1'b0)
  endtask : wb
  task automatic reg_wr(input logic [7:0] ad, input logic [7:0] d);
    host_u.start();
    wb({TARGET_ADDR_DEFAULT, 1'b0});
    wb(ad);
    wb(d);
    host_u.stop();
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] ad, input logic [7:0] exp);
    logic [7:0] q;
    logic a;
    host_u.start();
    wb({TARGET_ADDR_DEFAULT, 1'b0});
    wb(ad);
    host_u.start();
    wb({TARGET_ADDR_DEFAULT, 1'b1});
    host_u.byte_x(8'hff, 1'b1, q, a);
    host_u.stop();
    `CHK(q, exp)
  endtask : reg_rd
  task automatic pulse(input logic [19:0] ad, input logic [7:0] d);
    @(negedge clk_i);
    snoop_wr = 1'b1;
    snoop_addr = ad;
    snoop_data = d;
    @(negedge clk_i);
    snoop_wr = 1'b0;
    repeat (4) @(negedge clk_i);
  endtask : pulse
  task automatic tick();
    repeat (10) @(negedge clk_i);
  endtask : tick
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    repeat (60000) @(posedge clk_i);
    err_count++;
    summarize();
  end
  initial begin
    {rst_n_i, pin_a, pin_b, snoop_wr, snoop_addr, snoop_data} = '0;
    straps = 2'b10;
    repeat (20) @(negedge clk_i);
    rst_n_i = 1'b1;
    tick();
    `CHK(cfg, LANE_CFG_USB)
    reg_rd(GENERAL_CONTROL_ADDR, GENERAL_CONTROL_RST);
    reg_rd(DP_EQ_LANES_0_1_ADDR, 8'haa);
    reg_rd(SIDEBAND_SNOOP_STATUS_ADDR, 8'h00);
    reg_rd(SNOOP_LANE_CONTROL_ADDR, 8'h00);
    reg_rd(8'h40, 8'h00);
    straps = 2'b11;
    reg_wr(DP_EQ_LANES_2_3_ADDR, 8'h12);
    tick();
    `CHK(eq, 16'heeee)
    reg_rd(DP_EQ_LANES_2_3_ADDR, 8'hee);
    $display("test reset_and_straps done");
    reg_wr(SNOOP_LANE_CONTROL_ADDR, 8'h80);
    for (int i = 0; i < 4; i++) begin
      reg_wr(GENERAL_CONTROL_ADDR, 8'(i));
      tick();
      `CHK(cfg, 2'(i))
      `CHK(usb_en, i[0])
      `CHK(lane_en, base[i])
    end
    reg_wr(GENERAL_CONTROL_ADDR, 8'h06);
    reg_wr(SNOOP_LANE_CONTROL_ADDR, 8'h85);
    tick();
    `CHK(orient, 1'b1)
    `CHK(lane_en, 4'ha)
    $display("test config_table done");
    reg_wr(SNOOP_LANE_CONTROL_ADDR, 8'h05);
    pulse(SINK_POWER_ADDR, 8'h01);
    pulse(SINK_LANE_COUNT_ADDR, 8'h02);
    `CHK(lane_en, 4'h3)
    reg_rd(SIDEBAND_SNOOP_STATUS_ADDR, 8'h22);
    pulse(SINK_POWER_ADDR, 8'h02);
    `CHK(lane_en, 4'h0)
    reg_wr(SIDEBAND_SNOOP_STATUS_ADDR, 8'hff);
    reg_rd(SIDEBAND_SNOOP_STATUS_ADDR, 8'h42);
    reg_wr(GENERAL_CONTROL_ADDR, 8'h01);
    reg_rd(SIDEBAND_SNOOP_STATUS_ADDR, 8'h00);
    $display("test snoop done");
    {pin_a, pin_b} = 2'b11;
    tick();
    `CHK(hotplug, 1'b1)
    pin_b = 1'b0;
    reg_wr(GENERAL_CONTROL_ADDR, 8'h21);
    tick();
    `CHK(hotplug, 1'b0)
    reg_wr(GENERAL_CONTROL_ADDR, 8'h29);
    tick();
    `CHK(hotplug, 1'b1)
    reg_wr(GENERAL_CONTROL_ADDR, 8'h11);
    reg_wr(DP_EQ_LANES_0_1_ADDR, 8'h5c);
    reg_wr(DP_EQ_LANES_2_3_ADDR, 8'h3e);
    straps = 2'b00;
    tick();
    `CHK(eq, 16'h3e5c)
    reg_rd(DP_EQ_LANES_0_1_ADDR, 8'h5c);
    reg_wr(GENERAL_CONTROL_ADDR, 8'h01);
    tick();
    `CHK(eq, 16'h0000)
    $display("test hotplug_and_eq done");
    summarize();
  end
endmodule : redriver_lane_config_regs_tb
bind redriver_lane_config_regs redriver_cfg_checker chk_u (.*);
